/* File: pin_sync.sv */
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_in,
   output logic      pin_level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   wire  logic agree = (s2_ff == s3_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff    <= 1'b0;
         s2_ff    <= 1'b0;
         s3_ff    <= 1'b0;
         level_ff <= 1'b0;
      end else begin
         s1_ff    <= pin_in;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         level_ff <= agree ? s3_ff : level_ff;
      end
   end

   assign pin_level = level_ff;
endmodule
`default_nettype wire

/* File: power_on_soft_start_sequencer_tb_top.sv */
// Self-checking bench of the soft start sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_consts.svh"
module power_on_soft_start_sequencer_tb_top;
   localparam int dly_c[4]  = '{0, 20, 40, 80};
   localparam int ramp_c[4] = '{8, 16, 32, 64};
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd_q;
   logic        pready, pslverr, err_q, pwm_enable, output_nominal;
   logic        supply_on_pin = 1'b0, fault_flag = 1'b0;
   logic [15:0] ramp_level, stage_out;
   int          fail_count = 0, tests_run = 0, n;
   always #12.5 pclk = ~pclk;
   soft_start_sequencer #(.DLY_HALF_CYC(27'h14), .RAMP0_CYC(27'h8), .RAMP1_CYC(27'h10)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .supply_on_pin, .fault_flag, .pwm_enable, .ramp_level, .output_nominal);
   power_stage_model u_stage (.pclk, .presetn, .pwm_enable, .ramp_level, .stage_out);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rng(input int c, input int lo, input int hi);
      chk(32'(c >= lo && c <= hi), 32'h1);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic [7:0] v);
      apb(1'b1, `REG_SETTING_ADDR, {24'h0, v});
   endtask
   task automatic wait_sig(input logic nom, input logic v, output int c);
      c = 0;
      while ((nom ? output_nominal : pwm_enable) !== v && c < 3000) begin
         @(posedge pclk);
         c++;
      end
   endtask
   task automatic off();
      int k;
      cfg(8'h80);
      wait_sig(1'b0, 1'b0, k);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      apb(1'b0, `REG_SETTING_ADDR, 32'h0);
      chk(rd_q, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({rd_q[30:0], err_q}, 32'h1);
      apb(1'b1, `REG_STATUS_ADDR, 32'hFF);
      chk(err_q, 1'b1);
   endtask
   task automatic t_source;
      logic e;
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 4; c++) begin
            supply_on_pin <= c[1];
            cfg(8'(s << 6 | (c & 1) << 5));
            repeat (8) @(posedge pclk);
            apb(1'b0, `REG_STATUS_ADDR, 32'h0);
            e = (s == 0) | (s == 1 && c[1]) | (s == 2 && c[0]) | (s == 3 && c == 3);
            chk(rd_q[4], e);
         end
      end
      supply_on_pin <= 1'b0;
   endtask
   task automatic t_timing;
      for (int i = 0; i < 4; i++) begin
         off();
         cfg(8'(8'hA0 | i << 3 | i));
         wait_sig(1'b0, 1'b1, n);
         rng(n, dly_c[i], dly_c[i] + 5);
         wait_sig(1'b1, 1'b1, n);
         rng(n, ramp_c[i] - 1, ramp_c[i] + 3);
         chk(ramp_level, 16'hFFFF);
      end
   endtask
   task automatic t_stop;
      off();
      cfg(8'hA4); // Soft stop accepted with its longer fault switching
      wait_sig(1'b1, 1'b1, n);
      cfg(8'hA7);
      cfg(8'h87);
      wait_sig(1'b0, 1'b0, n);
      rng(n, 63, 68);
      cfg(8'hA5);
      wait_sig(1'b1, 1'b1, n);
      fault_flag <= 1'b1;
      wait_sig(1'b0, 1'b0, n);
      rng(n, 17, 26);
      fault_flag <= 1'b0;
   endtask
   task automatic t_cut;
      cfg(8'hA2);
      wait_sig(1'b1, 1'b1, n);
      fault_flag <= 1'b1;
      wait_sig(1'b0, 1'b0, n);
      rng(n, 1, 7);
      chk(ramp_level, 16'h0000);
      repeat (2) @(posedge pclk);
      chk(stage_out, 16'h0000);
      fault_flag <= 1'b0;
   endtask
   task automatic t_abandon;
      int k = 0;
      off();
      cfg(8'hB8);
      repeat (30) @(posedge pclk);
      cfg(8'h98);
      repeat (120) begin
         @(posedge pclk);
         if (pwm_enable !== 1'b0) k++;
      end
      chk(k, 0);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_source;
      t_timing;
      t_stop;
      t_cut;
      t_abandon;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      stop_test;
   end
endmodule
`default_nettype wire

/* File: power_stage_model.sv */
// Behavioural power stage driven by the sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pwm_enable,
   input  wire logic [15:0] ramp_level,
   output logic      [15:0] stage_out
);
   // Output collapses once switching stops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stage_out <= 16'h0000;
      else stage_out <= pwm_enable ? ramp_level : 16'h0000;
   end
endmodule
`default_nettype wire

/* File: seq_checker_sva.sv */
// Port assertions of the soft start sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_consts.svh"
module seq_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        supply_on_pin,
   input wire logic        fault_flag,
   input wire logic        pwm_enable,
   input wire logic [15:0] ramp_level,
   input wire logic        output_nominal
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_answer: assert property (psel && !penable |=> pready)
      else $error("setup not answered");
   a_unmapped_error: assert property (pready && paddr > `REG_STATUS_ADDR |->
      pslverr && prdata == 32'h0)
      else $error("unmapped access accepted");
   a_off_level_zero: assert property (!pwm_enable |-> ramp_level == 16'h0000)
      else $error("level while switching off");
   a_nominal_full: assert property (output_nominal |->
      pwm_enable && ramp_level == `RAMP_FULL)
      else $error("nominal without full level");
   a_start_low: assert property ($rose(pwm_enable) |->
      !output_nominal && ramp_level != `RAMP_FULL)
      else $error("start skipped the ramp");
   a_fault_stops: assert property (fault_flag [*8] |-> !output_nominal)
      else $error("fault left output on");
   a_stop_falls: assert property ($fell(output_nominal) |->
      (pwm_enable ? ramp_level <= $past(ramp_level) : ramp_level == 16'h0000))
      else $error("shutdown level rose");
endmodule
bind soft_start_sequencer seq_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .supply_on_pin, .fault_flag, .pwm_enable, .ramp_level,
   .output_nominal);
`default_nettype wire

/* File: sequencer_consts.svh */
// Register map, field positions and timing constants of the soft start sequencer
`ifndef SEQUENCER_CONSTS_SVH
`define SEQUENCER_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_SETTING_ADDR   12'h000
`define REG_STATUS_ADDR    12'h004
`define REG_SETTING_RESET  8'h00

// ----------------------------------------------------------------
// Fields of the setting register
// ----------------------------------------------------------------
`define FLD_SRC_HI         7
`define FLD_SRC_LO         6
`define FLD_SW_ON          5
`define FLD_DLY_HI         4
`define FLD_DLY_LO         3
`define FLD_SOFT_STOP      2
`define FLD_RAMP_HI        1
`define FLD_RAMP_LO        0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ             40000000
`define DLY_HALF_MS        500
`define DLY_ONE_MS         1000
`define DLY_TWO_MS         2000
`define RAMP_0_US          360
`define RAMP_1_MS          10
`define RAMP_2_MS          20
`define RAMP_3_MS          40
`define CNT_W              27
`define RAMP_LEVEL_W       16
`define RAMP_FULL          16'hFFFF

`endif

/* File: sequencer_pkg.sv */
// Types shared by the soft start sequencer
package sequencer_pkg;
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_DELAY = 3'b001,
      ST_RAMP  = 3'b010,
      ST_ON    = 3'b011,
      ST_STOP  = 3'b100
   } seq_state_t;
endpackage

/* File: soft_start_sequencer.sv */
// Turn-on delay, soft start ramp and soft stop sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "sequencer_consts.svh"
module soft_start_sequencer #(
   parameter logic [`CNT_W-1:0] DLY_HALF_CYC = `CNT_W'(64'(`DLY_HALF_MS) * `CLK_HZ / 1000),
   parameter logic [`CNT_W-1:0] DLY_ONE_CYC  = `CNT_W'(DLY_HALF_CYC * (`DLY_ONE_MS / `DLY_HALF_MS)),
   parameter logic [`CNT_W-1:0] DLY_TWO_CYC  = `CNT_W'(DLY_HALF_CYC * (`DLY_TWO_MS / `DLY_HALF_MS)),
   parameter logic [`CNT_W-1:0] RAMP0_CYC    = `CNT_W'(64'(`RAMP_0_US) * `CLK_HZ / 1000000),
   parameter logic [`CNT_W-1:0] RAMP1_CYC    = `CNT_W'(64'(`RAMP_1_MS) * `CLK_HZ / 1000),
   parameter logic [`CNT_W-1:0] RAMP2_CYC    = `CNT_W'(RAMP1_CYC * (`RAMP_2_MS / `RAMP_1_MS)),
   parameter logic [`CNT_W-1:0] RAMP3_CYC    = `CNT_W'(RAMP1_CYC * (`RAMP_3_MS / `RAMP_1_MS))
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     supply_on_pin,
   input  wire logic                     fault_flag,
   output logic                          pwm_enable,
   output logic      [`RAMP_LEVEL_W-1:0] ramp_level,
   output logic                          output_nominal
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [`CNT_W-1:0] ramp_cycles(input logic [1:0] sel);
      case (sel)
         2'h0:    ramp_cycles = RAMP0_CYC;
         2'h1:    ramp_cycles = RAMP1_CYC;
         2'h2:    ramp_cycles = RAMP2_CYC;
         default: ramp_cycles = RAMP3_CYC;
      endcase
   endfunction

   function automatic logic [`CNT_W-1:0] delay_cycles(input logic [1:0] sel);
      case (sel)
         2'h0:    delay_cycles = '0;
         2'h1:    delay_cycles = DLY_HALF_CYC;
         2'h2:    delay_cycles = DLY_ONE_CYC;
         default: delay_cycles = DLY_TWO_CYC;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin inputs
   // ----------------------------------------------------------------
   logic pin_level;
   logic fault_level;

   pin_sync u_pin_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_in    (supply_on_pin),
      .pin_level (pin_level)
   );

   pin_sync u_fault_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_in    (fault_flag),
      .pin_level (fault_level)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [7:0]  setting_ff;
   logic [31:0] prdata_ff;
   logic        pslverr_ff;
   logic        pready_ff;
   sequencer_pkg::seq_state_t state_ff;
   sequencer_pkg::seq_state_t nxt_state;
   logic        on_ctl;
   logic        pwm_enable_ff;
   logic        output_nominal_ff;

   wire logic       setup      = psel && !penable;
   wire logic       hit_set    = (paddr == `REG_SETTING_ADDR);
   wire logic       hit_stat   = (paddr == `REG_STATUS_ADDR);
   wire logic       acc_done   = psel && penable && pready_ff;
   wire logic       wr_set     = acc_done && pwrite && hit_set;
   wire logic [1:0] src_sel    = setting_ff[`FLD_SRC_HI:`FLD_SRC_LO];
   wire logic       sw_on      = setting_ff[`FLD_SW_ON];
   wire logic [1:0] dly_sel    = setting_ff[`FLD_DLY_HI:`FLD_DLY_LO];
   wire logic       soft_stop  = setting_ff[`FLD_SOFT_STOP];
   wire logic [1:0] ramp_sel   = setting_ff[`FLD_RAMP_HI:`FLD_RAMP_LO];
   wire logic [31:0] stat_word = {22'h000000, fault_level, pin_level, pwm_enable_ff,
                                  output_nominal_ff, 1'b0, on_ctl, 1'b0, state_ff};
   wire logic [31:0] rd_word   = hit_set  ? {24'h000000, setting_ff} :
                                 hit_stat ? stat_word : 32'h00000000;

   // ----------------------------------------------------------------
   // Supply-on selection
   // ----------------------------------------------------------------
   always_comb begin
      case (src_sel)
         2'h0:    on_ctl = 1'b1;
         2'h1:    on_ctl = pin_level;
         2'h2:    on_ctl = sw_on;
         default: on_ctl = pin_level && sw_on;
      endcase
   end

   // Fault forces shutdown while supply-on is held
   wire logic run_req = on_ctl && !fault_level;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   logic [`CNT_W-1:0]        cnt_ff;
   logic [`CNT_W-1:0]        nxt_cnt;
   logic [`RAMP_LEVEL_W-1:0] ramp_level_ff;
   logic [`RAMP_LEVEL_W-1:0] nxt_level;

   wire logic [`CNT_W-1:0] ramp_len = ramp_cycles(ramp_sel);
   wire logic [`CNT_W-1:0] dly_len  = delay_cycles(dly_sel);
   wire logic [`CNT_W+`RAMP_LEVEL_W-1:0] scaled =
      ({{`RAMP_LEVEL_W{1'b0}}, cnt_ff} * `RAMP_FULL) / {{`RAMP_LEVEL_W{1'b0}}, ramp_len};
   wire logic [`RAMP_LEVEL_W-1:0] frac = scaled[`RAMP_LEVEL_W-1:0];
   // Falling level from full scale; ST_STOP takes the lower of it and the held level
   wire logic [`RAMP_LEVEL_W-1:0] fall = `RAMP_FULL - frac;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_level = ramp_level_ff;
      case (state_ff)
         sequencer_pkg::ST_OFF: begin
            nxt_level = '0;
            nxt_cnt   = '0;
            if (run_req) begin
               nxt_state = sequencer_pkg::ST_DELAY;
            end
         end
         sequencer_pkg::ST_DELAY: begin
            if (!run_req) begin
               nxt_state = sequencer_pkg::ST_OFF;
               nxt_cnt   = '0;
            end else if (cnt_ff >= dly_len) begin
               nxt_state = sequencer_pkg::ST_RAMP;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + `CNT_W'(1);
            end
         end
         sequencer_pkg::ST_RAMP: begin
            if (!run_req) begin
               nxt_state = soft_stop ? sequencer_pkg::ST_STOP
                                     : sequencer_pkg::ST_OFF;
               nxt_cnt   = '0;
               nxt_level = soft_stop ? ramp_level_ff : '0;
            end else if (cnt_ff + `CNT_W'(1) >= ramp_len) begin
               nxt_state = sequencer_pkg::ST_ON;
               nxt_level = `RAMP_FULL;
            end else begin
               nxt_cnt   = cnt_ff + `CNT_W'(1);
               nxt_level = frac;
            end
         end
         sequencer_pkg::ST_ON: begin
            nxt_level = `RAMP_FULL;
            nxt_cnt   = '0;
            if (!run_req) begin
               nxt_state = soft_stop ? sequencer_pkg::ST_STOP
                                     : sequencer_pkg::ST_OFF;
               nxt_level = soft_stop ? `RAMP_FULL : '0;
            end
         end
         sequencer_pkg::ST_STOP: begin
            if (cnt_ff + `CNT_W'(1) >= ramp_len) begin
               nxt_state = sequencer_pkg::ST_OFF;
               nxt_level = '0;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt   = cnt_ff + `CNT_W'(1);
               nxt_level = (fall < ramp_level_ff) ? fall : ramp_level_ff;
            end
         end
         default: begin
            nxt_state = sequencer_pkg::ST_OFF;
            nxt_cnt   = '0;
            nxt_level = '0;
         end
      endcase
   end

   wire logic nxt_pwm = (nxt_state != sequencer_pkg::ST_OFF) &&
                        (nxt_state != sequencer_pkg::ST_DELAY);
   wire logic nxt_nom = (nxt_state == sequencer_pkg::ST_ON);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff          <= sequencer_pkg::ST_OFF;
         cnt_ff            <= '0;
         ramp_level_ff     <= '0;
         pwm_enable_ff     <= 1'b0;
         output_nominal_ff <= 1'b0;
      end else begin
         state_ff          <= nxt_state;
         cnt_ff            <= nxt_cnt;
         ramp_level_ff     <= nxt_level;
         pwm_enable_ff     <= nxt_pwm;
         output_nominal_ff <= nxt_nom;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setting_ff <= `REG_SETTING_RESET;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
         pready_ff  <= 1'b0;
      end else begin
         setting_ff <= wr_set ? pwdata[7:0] : setting_ff;
         prdata_ff  <= setup ? rd_word : prdata_ff;
         pslverr_ff <= setup ? !(hit_set || (hit_stat && !pwrite)) : pslverr_ff;
         pready_ff  <= setup;
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign pwm_enable     = pwm_enable_ff;
   assign ramp_level     = ramp_level_ff;
   assign output_nominal = output_nominal_ff;
endmodule
`default_nettype wire
